/* core/sfpc_top.sv */
// Top: serial flash pin control with APB register access
`timescale 1ns/1ps
`default_nettype none
module sfpc_top
  import sfpc_pkg::*;
(
  // System
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CE_I,
  // APB slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [APB_AW-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // Flash pins
  input  wire logic              SCK_I,
  input  wire logic              CS_N_I,
  input  wire logic [3:0]        DQ_I,
  output logic      [3:0]        DQ_O,
  output logic      [3:0]        DQ_OE_O,
  // Power state
  output logic                   STANDBY_O
);
  logic [2:0]   pin_q;
  logic         cs_q;
  logic         p3_q;
  logic         wp_q;
  logic         tgl_s;
  logic         tgl_prev;
  logic         rx_evt;
  logic [7:0]   lk_rx;
  logic         lk_first;
  logic         lk_tgl;
  logic [1:0]   width;
  logic         pin_fsel;
  logic [7:0]   status;
  logic [7:0]   txdata;
  logic [1:0]   fr_width;
  logic [7:0]   fr_stat;
  logic [7:0]   fr_data;
  logic         armed;
  logic         hold_act;
  logic         rst_mode;
  logic         refused;
  sfpc_pin_type pin_fn;
  logic [7:0]   instr;
  logic [7:0]   rx_data;
  logic         rx_first;
  logic         wdis;
  logic         quad_en;
  logic         prot;
  logic [1:0]   sync_full;
  logic         ser_wr;
  logic         st_wr;
  logic [7:0]   st_wdata;
  logic         apb_setup;
  logic         apb_wr;
  logic [31:0]  rdata;
  logic         hit;
  logic         link_clr;

  // Pins are asynchronous to CLK_I
  sfpc_sync #(.W(3), .ASYNC(1'b0), .RST_VAL(3'b111)) u_pin_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .en_i (CE_I),
    .d_i  ({CS_N_I, DQ_I[3], DQ_I[2]}),
    .q_o  (pin_q)
  );

  sfpc_sync #(.W(1), .ASYNC(1'b0), .RST_VAL(1'b0)) u_tgl_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .en_i (CE_I),
    .d_i  (lk_tgl),
    .q_o  (tgl_s)
  );

  assign cs_q   = pin_q[2];
  assign p3_q   = pin_q[1];
  assign wp_q   = pin_q[0];
  assign rx_evt = tgl_s ^ tgl_prev;
  assign wdis    = status[ST_WDIS];
  assign quad_en = status[ST_QUAD];

  // [RULE3] [RULE4] frame logic cleared until armed and while deselected
  assign link_clr = CS_N_I | ~armed;

  sfpc_link u_link (
    .sck_i  (SCK_I),
    .rst_i  (SYS_RST_I),
    .clr_i  (link_clr),
    .float_i(hold_act),
    .en_i   (CE_I),
    .hold_i (hold_act),
    .width_i(fr_width),
    .stat_i (fr_stat),
    .data_i (fr_data),
    .dq_i   (DQ_I),
    .dq_o   (DQ_O),
    .dq_oe_o(DQ_OE_O),
    .rx_o   (lk_rx),
    .first_o(lk_first),
    .tgl_o  (lk_tgl)
  );

  // APB decode
  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_wr    = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (PADDR_I)
      OFS_CTRL: begin
        rdata[CTRL_WIDTH +: 2] = width;
        rdata[CTRL_PINFN]      = pin_fsel;
      end
      OFS_STATUS: rdata[7:0] = status;
      OFS_TXDATA: rdata[7:0] = txdata;
      OFS_RXDATA: begin
        rdata[7:0]      = rx_data;
        rdata[RX_FIRST] = rx_first;
      end
      OFS_STATE: begin
        rdata[STA_SEL]     = ~cs_q;
        rdata[STA_STBY]    = STANDBY_O;
        rdata[STA_PAUSE]   = hold_act;
        rdata[STA_RSTMODE] = rst_mode;
        rdata[STA_WP]      = wp_q;
        rdata[STA_REFUSED] = refused;
      end
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait answer: ready and data registered at the setup edge
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= apb_setup;
      PRDATA_O  <= (apb_setup && !PWRITE_I) ? rdata : 32'h0000_0000;
      PSLVERR_O <= apb_setup & ~hit;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      width    <= WIDTH_RST;
      pin_fsel <= PINFN_RST;
      txdata   <= TXDATA_RST;
    end else if (CE_I && apb_wr) begin
      if (PADDR_I == OFS_CTRL) begin
        width    <= PWDATA_I[CTRL_WIDTH +: 2];
        pin_fsel <= PWDATA_I[CTRL_PINFN];
      end
      if (PADDR_I == OFS_TXDATA) begin
        txdata <= PWDATA_I[7:0];
      end
    end
  end

  // Words seen by the link change only while deselected, so they are stable in a frame
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      fr_width <= WIDTH_RST;
      fr_stat  <= STATUS_RST;
      fr_data  <= TXDATA_RST;
    end else if (CE_I && cs_q) begin
      fr_width <= width;
      fr_stat  <= status;
      fr_data  <= txdata;
    end
  end

  // Received bytes
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tgl_prev <= 1'b0;
      rx_data  <= 8'h00;
      rx_first <= 1'b0;
      instr    <= 8'h00;
    end else if (CE_I) begin
      tgl_prev <= tgl_s;
      if (rx_evt) begin
        rx_data  <= lk_rx;
        rx_first <= lk_first;
        if (lk_first) begin
          instr <= lk_rx;
        end
      end
    end
  end

  // Status writes: serial second byte takes priority over APB
  assign ser_wr   = rx_evt & ~lk_first & (instr == CMD_WR_STATUS);
  assign st_wr    = ser_wr | (apb_wr & (PADDR_I == OFS_STATUS));
  assign st_wdata = ser_wr ? lk_rx : PWDATA_I[7:0];

  // [RULE8] disable bit with protect pin low
  // [RULE10] quad enable overrides the pin
  assign prot = wdis & ~wp_q & ~quad_en;

  // [RULE9] open when disable bit clear
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      status <= STATUS_RST;
    end else if (CE_I && st_wr && !prot) begin
      status <= st_wdata & ST_WMASK;
    end
  end

  // Sticky refusal flag; a new refusal beats a write-one clear
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      refused <= 1'b0;
    end else if (CE_I) begin
      if (st_wr && prot) begin
        refused <= 1'b1;
      end else if (apb_wr && PADDR_I == OFS_STATE && PWDATA_I[STA_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  // [RULE11] fourth pin function
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pin_fn <= FN_PAUSE;
    end else if (CE_I) begin
      pin_fn <= quad_en ? FN_DATA : (pin_fsel ? FN_RESET : FN_PAUSE);
    end
  end

  // [RULE13] pause floats output while selected
  // [RULE14] reset pin low enters reset mode
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      hold_act <= 1'b0;
      rst_mode <= 1'b0;
    end else if (CE_I) begin
      unique case (pin_fn)
        FN_PAUSE: begin
          hold_act <= ~p3_q & ~cs_q;
          rst_mode <= 1'b0;
        end
        FN_RESET: begin
          hold_act <= 1'b0;
          rst_mode <= ~p3_q;
        end
        FN_DATA: begin
          hold_act <= 1'b0;
          rst_mode <= 1'b0;
        end
        default: begin
          hold_act <= 1'b0;
          rst_mode <= 1'b0;
        end
      endcase
    end
  end

  // Synchroniser reset value reads as deselected, so arming waits until it holds the pin
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync_full <= 2'b00;
    end else if (CE_I) begin
      sync_full <= {sync_full[0], 1'b1};
    end
  end

  // [RULE17] rearm only on a deselect after reset mode
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      armed <= 1'b0;
    end else if (CE_I) begin
      if (rst_mode) begin
        armed <= 1'b0;
      end else if (cs_q && sync_full[1]) begin
        armed <= 1'b1;
      end
    end
  end

  // [RULE2] standby follows deselect
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      STANDBY_O <= 1'b1;
    end else if (CE_I) begin
      STANDBY_O <= cs_q;
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_cs_float;
    (cs_q && $past(cs_q)) |-> (DQ_OE_O == 4'h0);
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("driving while deselected"); // [RULE1]

  property p_standby;
    (STANDBY_O && CE_I) |-> (DQ_OE_O == 4'h0 && !hold_act);
  endproperty
  a_standby: assert property (p_standby) else $error("standby with activity"); // [RULE2]

  property p_armed;
    (!armed && !cs_q && CE_I) |=> !armed;
  endproperty
  a_armed: assert property (p_armed) else $error("armed without select edge"); // [RULE3]

  property p_ignore;
    (cs_q && $past(cs_q) && $past(cs_q, 2) && $past(cs_q, 3)) |-> !rx_evt;
  endproperty
  a_ignore: assert property (p_ignore) else $error("byte taken while deselected"); // [RULE4]

  property p_prot;
    (st_wr && prot && CE_I) |=> ($stable(status) && refused);
  endproperty
  a_prot: assert property (p_prot) else $error("protected status written"); // [RULE8]

  property p_open;
    (st_wr && !wdis && CE_I) |=> (status == ($past(st_wdata) & ST_WMASK));
  endproperty
  a_open: assert property (p_open) else $error("open status write lost"); // [RULE9]

  property p_quad;
    (st_wr && quad_en && CE_I) |=> (status == ($past(st_wdata) & ST_WMASK));
  endproperty
  a_quad: assert property (p_quad) else $error("protect pin acted with quad on"); // [RULE10]

  property p_fn;
    (CE_I && quad_en && $past(quad_en) && pin_fsel) |=> (pin_fn == FN_DATA && !rst_mode);
  endproperty
  a_fn: assert property (p_fn) else $error("quad enable lost priority"); // [RULE11]

  property p_hold;
    (hold_act && $past(hold_act)) |-> (DQ_OE_O == 4'h0);
  endproperty
  a_hold: assert property (p_hold) else $error("output driven in pause"); // [RULE13]

  property p_reset;
    (rst_mode && CE_I) |=> !armed ##1 (DQ_OE_O == 4'h0);
  endproperty
  a_reset: assert property (p_reset) else $error("outputs live in reset mode"); // [RULE14]

  property p_release;
    ($fell(rst_mode) && !cs_q && CE_I) |-> !armed;
  endproperty
  a_release: assert property (p_release) else $error("rearmed without deselect"); // [RULE17]
endmodule : sfpc_top
`default_nettype wire

/* core/sfpc_pkg.sv */
// Package: constants and types for the serial flash pin control block
// Function
// [RULE1] Chip select high deselects the device; all outputs float.
// [RULE2] Deselected means standby; chip select low makes the device active.
// [RULE3] No instruction accepted before a chip-select falling edge after power-up.
// [RULE4] Data lines are ignored while chip select is high.
// [RULE5] Single-bit input on data line 0, sampled on rising clock edges.
// [RULE6] Single-bit output on data line 1, changed on falling clock edges.
// [RULE7] Dual and quad use lines bidirectionally; quad adds lines 2 and 3.
// [RULE8] Disable bit set and protect pin low refuses status writes.
// [RULE9] Disable bit clear allows status writes whatever the protect pin.
// [RULE10] Quad enable turns the protect pin into pure data line 2.
// [RULE11] Fourth pin is data, pause, or reset by quad enable and function bit.
// [RULE12] Pause suspends the serial sequence without resetting it.
// [RULE13] Pause low with chip select low floats the output; high resumes.
// [RULE14] Reset pin low enters reset mode and floats outputs.
// [RULE15] Master should not assert reset during internal write or erase.
// [RULE16] Clock modes 0 and 3: rising edge samples, falling edge drives.
// [RULE17] Leaving reset mode idles the interface until a fresh select edge.
package sfpc_pkg;
  // APB map, byte addresses
  localparam int unsigned APB_AW      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_TXDATA  = 8'h08;
  localparam logic [7:0]  OFS_RXDATA  = 8'h0C;
  localparam logic [7:0]  OFS_STATE   = 8'h10;
  // Control fields
  localparam int unsigned CTRL_WIDTH  = 0;
  localparam int unsigned CTRL_PINFN  = 2;
  localparam logic [1:0]  WIDTH_RST   = 2'h0;
  localparam logic        PINFN_RST   = 1'b0;
  // Transfer widths
  localparam logic [1:0]  WIDTH_SINGLE = 2'h0;
  localparam logic [1:0]  WIDTH_DUAL   = 2'h1;
  localparam logic [1:0]  WIDTH_QUAD   = 2'h2;
  // Flash status byte
  localparam int unsigned ST_WDIS     = 7;
  localparam int unsigned ST_QUAD     = 6;
  localparam logic [7:0]  ST_WMASK    = 8'hFC;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [7:0]  TXDATA_RST  = 8'h00;
  // Received byte and state fields
  localparam int unsigned RX_FIRST    = 8;
  localparam int unsigned STA_SEL     = 0;
  localparam int unsigned STA_STBY    = 1;
  localparam int unsigned STA_PAUSE   = 2;
  localparam int unsigned STA_RSTMODE = 3;
  localparam int unsigned STA_WP      = 4;
  localparam int unsigned STA_REFUSED = 5;
  // Serial instructions
  localparam logic [7:0]  CMD_WR_STATUS = 8'h01;
  localparam logic [7:0]  CMD_RD_DATA   = 8'h03;
  localparam logic [7:0]  CMD_RD_STATUS = 8'h05;
  // Function of the fourth data pin
  typedef enum logic [1:0] {
    FN_PAUSE = 2'h0,
    FN_RESET = 2'h1,
    FN_DATA  = 2'h3
  } sfpc_pin_type;
endpackage : sfpc_pkg

/* core/sfpc_sync.sv */
// Two-flop level synchroniser with selectable reset style
`timescale 1ns/1ps
`default_nettype none
module sfpc_sync #(
  parameter int unsigned   W       = 1,
  parameter bit            ASYNC   = 1'b0,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // Clock, reset and enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  if (ASYNC) begin : g_async
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta <= RST_VAL;
        q_o  <= RST_VAL;
      end else if (en_i) begin
        meta <= d_i;
        q_o  <= meta;
      end
    end
  end else begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta <= RST_VAL;
        q_o  <= RST_VAL;
      end else if (en_i) begin
        meta <= d_i;
        q_o  <= meta;
      end
    end
  end
endmodule : sfpc_sync
`default_nettype wire

/* core/sfpc_link.sv */
// Serial shifter running on the flash serial clock
`timescale 1ns/1ps
`default_nettype none
module sfpc_link
  import sfpc_pkg::*;
(
  // Clock and clears
  input  wire logic       sck_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,
  input  wire logic       float_i,
  // Levels and frame-stable words
  input  wire logic       en_i,
  input  wire logic       hold_i,
  input  wire logic [1:0] width_i,
  input  wire logic [7:0] stat_i,
  input  wire logic [7:0] data_i,
  // Pins
  input  wire logic [3:0] dq_i,
  output logic      [3:0] dq_o,
  output logic      [3:0] dq_oe_o,
  // Received bytes
  output logic      [7:0] rx_o,
  output logic            first_o,
  output logic            tgl_o
);
  logic [1:0] lvl;
  logic       run;
  logic       oe_clr;
  logic [3:0] step;
  logic [3:0] oe_mask;
  logic [7:0] nxt;
  logic [3:0] drive;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       seen;
  logic       rd;
  logic       rd_st;
  logic       done;
  logic [7:0] tsh;
  logic [3:0] tcnt;
  logic [7:0] cur;

  sfpc_sync #(.W(2), .ASYNC(1'b1), .RST_VAL(2'b10)) u_lvl (
    .clk_i(sck_i), .rst_i(rst_i), .en_i(1'b1), .d_i({en_i, hold_i}), .q_o(lvl));

  // [RULE12] pause freezes the sequence
  assign run    = lvl[1] & ~lvl[0];
  assign oe_clr = clr_i | float_i;
  assign done   = (cnt + step) == 4'h8;
  assign cur    = (tcnt == 4'h0) ? (rd_st ? stat_i : data_i) : tsh;

  // [RULE7] lane use by width
  always_comb begin
    case (width_i)
      WIDTH_QUAD: begin
        step    = 4'h4;
        oe_mask = 4'hF;
        nxt     = {sh[3:0], dq_i};
        drive   = cur[7:4];
      end
      WIDTH_DUAL: begin
        step    = 4'h2;
        oe_mask = 4'h3;
        nxt     = {sh[5:0], dq_i[1:0]};
        drive   = {2'b00, cur[7:6]};
      end
      default: begin
        step    = 4'h1;
        oe_mask = 4'h2;
        nxt     = {sh[6:0], dq_i[0]};
        drive   = {2'b00, cur[7], 1'b0};
      end
    endcase
  end

  // [RULE5] [RULE16] sample on rising edges
  always_ff @(posedge sck_i or posedge clr_i) begin
    if (clr_i) begin
      sh    <= 8'h00;
      cnt   <= 4'h0;
      seen  <= 1'b0;
      rd    <= 1'b0;
      rd_st <= 1'b0;
    end else if (run) begin
      sh  <= nxt;
      cnt <= done ? 4'h0 : cnt + step;
      if (done) begin
        seen <= 1'b1;
      end
      if (done && !seen) begin
        rd    <= (nxt == CMD_RD_DATA) || (nxt == CMD_RD_STATUS);
        rd_st <= nxt == CMD_RD_STATUS;
      end
    end
  end

  // Completed byte stays put for a whole byte time so the system side can copy it
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      rx_o    <= 8'h00;
      first_o <= 1'b0;
      tgl_o   <= 1'b0;
    end else if (run && done) begin
      rx_o    <= nxt;
      first_o <= ~seen;
      tgl_o   <= ~tgl_o;
    end
  end

  // [RULE6] drive on falling edges
  always_ff @(negedge sck_i or posedge clr_i) begin
    if (clr_i) begin
      tsh  <= 8'h00;
      tcnt <= 4'h0;
      dq_o <= 4'h0;
    end else if (run && rd) begin
      tsh  <= cur << step;
      tcnt <= ((tcnt + step) == 4'h8) ? 4'h0 : tcnt + step;
      dq_o <= drive;
    end
  end

  // [RULE1] drivers released at once
  always_ff @(negedge sck_i or posedge oe_clr) begin
    if (oe_clr) begin
      dq_oe_o <= 4'h0;
    end else begin
      dq_oe_o <= (run && rd) ? oe_mask : 4'h0;
    end
  end
endmodule : sfpc_link
`default_nettype wire

/* tb/sfpc_master.sv */
// SPI master model that drives the flash pins of the block
`timescale 1ns/1ps
`default_nettype none
module sfpc_master
  import sfpc_pkg::*;
(
  // Pins seen by the device
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] dq_o,
  // Device drive
  input  wire logic [3:0] dev_dq_i,
  input  wire logic [3:0] dev_oe_i
);
  logic [3:0] drv;
  bit         mode3;
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b0;
    drv    = 4'hC;
    mode3  = 1'b0;
  end
  // Wire level: the device wins while it drives; released lanes toggle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq_o[i] = dev_oe_i[i] ? dev_dq_i[i] : drv[i];
    end
  end
  // Protect and fourth-pin levels outside quad lanes
  task automatic pins(input logic wp, input logic pz);
    drv[3:2] = {pz, wp};
  endtask : pins
  // idle clock level set, then a falling select
  task automatic start(input bit m3);
    #203;
    mode3  = m3;
    sck_o  = m3;
    #40;
    cs_n_o = 1'b0;
    #100;
  endtask : start
  // clock back to its idle level before deselect
  task automatic stop();
    #40;
    sck_o  = mode3;
    #40;
    cs_n_o = 1'b1;
    #20;
  endtask : stop
  // drive after falling edge, sample on rising edge
  task automatic xbyte(input logic [7:0] b, input logic [1:0] w, input bit rd,
                       output logic [7:0] r);
    int         n;
    logic [3:0] m;
    logic [3:0] g;
    n = (w == WIDTH_QUAD) ? 4 : (w == WIDTH_DUAL) ? 2 : 1;
    m = (w == WIDTH_QUAD) ? 4'hF : 4'h3;
    r = 8'h00;
    for (int k = 8 - n; k >= 0; k -= n) begin
      sck_o = 1'b0;
      g = 4'(b >> k);
      if (rd) drv = drv ^ m;
      else if (n == 1) drv[1:0] = {~drv[1], g[0]};
      else drv = (drv & ~m) | (g & m);
      #16;
      sck_o = 1'b1;
      r = (n == 1) ? {r[6:0], dq_o[1]} : 8'((16'(r) << n) | 16'(dq_o & m));
      #16;
    end
  endtask : xbyte
endmodule : sfpc_master
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the serial flash pin control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfpc_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, sck, cs_n, standby, e;
  logic [7:0]  paddr, r, c, x;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  dqi, dqo, dqoe, oe;
  logic [1:0]  w;
  int          bad_count, n_checks;

  sfpc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SCK_I(sck), .CS_N_I(cs_n), .DQ_I(dqi), .DQ_O(dqo), .DQ_OE_O(dqoe),
    .STANDBY_O(standby));
  sfpc_master m (.sck_o(sck), .cs_n_o(cs_n), .dq_o(dqi), .dev_dq_i(dqo), .dev_oe_i(dqoe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s: got %h want %h", $time, s, got, exp);
    end
  endtask : chk

  // Ready and read data are taken as they stand at the edge that samples them
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t apb ready timeout", $time);
      summarize();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] v,
                     input string s);
    apb(1'b0, a, 32'h0);
    chk(d & mk, v, s);
  endtask : rdc

  task automatic rdfrm(input bit m3, input logic [1:0] wd, input logic [7:0] cmd);
    m.start(m3);
    m.xbyte(cmd, wd, 1'b0, r);
    m.xbyte(8'h00, wd, 1'b1, r);
  endtask : rdfrm

  task automatic sws(input logic [7:0] v);
    m.start(1'b0);
    m.xbyte(CMD_WR_STATUS, WIDTH_SINGLE, 1'b0, r);
    m.xbyte(v, WIDTH_SINGLE, 1'b0, r);
    m.stop();
  endtask : sws

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h0, "status reset");
    rdc(OFS_TXDATA, 32'hFFFFFFFF, 32'h0, "txdata reset");
    rdc(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk(e, 1'b1, "unmapped error");
    $display("test registers done");
    // Select held low since power-up: no falling edge yet
    m.xbyte(CMD_RD_STATUS, WIDTH_SINGLE, 1'b0, r);
    m.xbyte(8'h00, WIDTH_SINGLE, 1'b1, r);
    chk(dqoe, 4'h0, "unarmed drive");
    m.stop();
    rdc(OFS_RXDATA, 32'h1FF, 32'h0, "unarmed rx");
    m.xbyte(CMD_RD_STATUS, WIDTH_SINGLE, 1'b0, r);
    chk(dqoe, 4'h0, "deselected drive");
    chk(standby, 1'b1, "standby");
    rdc(OFS_RXDATA, 32'h1FF, 32'h0, "deselected rx");
    $display("test select done");
    apb(1'b1, OFS_STATUS, 32'h83);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h80, "status ro bits");
    m.pins(1'b0, 1'b1);
    #100;
    apb(1'b1, OFS_STATUS, 32'h3C);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h80, "apb write refused");
    rdc(OFS_STATE, 32'h30, 32'h20, "refused flag, pin low");
    apb(1'b1, OFS_STATE, 32'h20);
    rdc(OFS_STATE, 32'h20, 32'h0, "flag cleared");
    m.pins(1'b1, 1'b1);
    #100;
    apb(1'b1, OFS_STATUS, 32'hC0);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'hC0, "pin high allows");
    m.pins(1'b0, 1'b1);
    #100;
    apb(1'b1, OFS_STATUS, 32'hC4);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'hC4, "quad enable lifts pin");
    apb(1'b1, OFS_STATUS, 32'h04);
    apb(1'b1, OFS_STATUS, 32'h08);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h08, "disable bit clear");
    $display("test protection done");
    m.pins(1'b1, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h5C);
    apb(1'b1, OFS_TXDATA, 32'hA5);
    for (int i = 0; i < 12; i++) begin
      w = 2'(i / 4);
      c = i[0] ? CMD_RD_DATA : CMD_RD_STATUS;
      x = i[0] ? 8'hA5 : 8'h5C;
      oe = (w == WIDTH_QUAD) ? 4'hF : (w == WIDTH_DUAL) ? 4'h3 : 4'h2;
      apb(1'b1, OFS_CTRL, 32'(w) | 32'h4);
      rdfrm(i[1], w, c);
      chk(standby, 1'b0, "active");
      chk(r, x, "read byte");
      chk(dqoe, oe, "lanes driven");
      m.xbyte(8'h00, w, 1'b1, r);
      chk(r, x, "repeat byte");
      m.stop();
      chk(dqoe, 4'h0, "float on deselect");
      m.pins(1'b1, 1'b1);
    end
    $display("test widths done");
    apb(1'b1, OFS_CTRL, 32'h0);
    sws(8'h88);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h88, "serial write");
    rdc(OFS_RXDATA, 32'h1FF, 32'h88, "rx data byte");
    m.pins(1'b0, 1'b1);
    sws(8'h00);
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h88, "serial refused");
    rdc(OFS_STATE, 32'h20, 32'h20, "serial refused flag");
    $display("test serial write done");
    m.pins(1'b1, 1'b1);
    rdfrm(1'b0, WIDTH_SINGLE, CMD_RD_STATUS);
    m.pins(1'b1, 1'b0);
    #200;
    chk(dqoe[1], 1'b0, "paused output floats");
    rdc(OFS_STATE, 32'h4, 32'h4, "paused");
    m.pins(1'b1, 1'b1);
    #200;
    m.xbyte(8'h00, WIDTH_SINGLE, 1'b1, r);
    chk(r, 8'h88, "resumed byte");
    m.stop();
    $display("test pause done");
    apb(1'b1, OFS_CTRL, 32'h4);
    // reset pin pulled only while no write runs
    m.pins(1'b1, 1'b0);
    #200;
    rdc(OFS_STATE, 32'h8, 32'h8, "reset mode");
    rdfrm(1'b0, WIDTH_SINGLE, CMD_RD_STATUS);
    chk(dqoe, 4'h0, "reset mode floats");
    m.pins(1'b1, 1'b1);
    #200;
    m.xbyte(8'h00, WIDTH_SINGLE, 1'b1, r);
    chk(dqoe, 4'h0, "no rearm while selected");
    m.stop();
    rdfrm(1'b1, WIDTH_SINGLE, CMD_RD_STATUS);
    chk(r, 8'h88, "after reset mode");
    chk(dqoe, 4'h2, "drive after reset mode");
    m.stop();
    $display("test reset pin done");
    summarize();
  end
endmodule : tb
`default_nettype wire
